// file: include/tss_defines.vh
// Constants for the task scheduler and scan watchdog.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSS_CLK_MHZ          125
`define TSS_MS_CYCLES        (`TSS_CLK_MHZ * 1000)
`define TSS_TICK_MS          10
`define TSS_TICK_CYCLES      (`TSS_TICK_MS * `TSS_MS_CYCLES)
`define TSS_WDOG_MS          300
`define TSS_WDOG_TICKS       (`TSS_WDOG_MS / `TSS_TICK_MS)
`define TSS_RETRIG_US        45
`define TSS_RETRIG_CYCLES    (`TSS_RETRIG_US * `TSS_CLK_MHZ)
`define TSS_PERIOD_DEF_MS    100
// 100 ms default held as a 16-bit count of 10 ms ticks
`define TSS_PERIOD_DEF       16'h000A

// ----------------------------------------------------------------
// Task codes on run_task_o
// ----------------------------------------------------------------
`define TSS_T_NONE           3'h0
`define TSS_T_CYCLIC         3'h1
`define TSS_T_INTR           3'h2
`define TSS_T_PERIODIC       3'h3
`define TSS_T_MANUAL         3'h4
`define TSS_T_POWER          3'h5
`define TSS_T_BATT           3'h6
`define TSS_T_RETRIG         3'h7

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define TSS_A_CTRL           12'h000
`define TSS_A_PERIOD         12'h004
`define TSS_A_STATUS         12'h008
`define TSS_A_CMD            12'h00C
`define TSS_A_PRESENT        12'h010
// CTRL bits
`define TSS_CTRL_PINT_EN     0
`define TSS_CTRL_CNT_EN      1
`define TSS_CTRL_INT_DIS     2
// CMD bits (write one to pulse)
`define TSS_CMD_DONE         0
`define TSS_CMD_RETRIG       1
`define TSS_CMD_CLR_STOP     2
// PRESENT bits, one per task code
`define TSS_PRESENT_RST      7'h7F

`endif

// file: logic/tss_scheduler.v
// Task scheduler with scan watchdog for a small controller.
// Assumes APB master on clk_i; pins from outside are async.
//
// Summary of operation
// - Arm watchdog per cycle; 300 ms expiry stops
// - Cyclic task only when present, powered, RUN
// - Cyclic preempted by interrupt or periodic task
// - Cyclic task never preempts anything
// - Interrupt task on input or counter match
// - Interrupt needs enables, presence, no disable, RUN
// - Interrupt task never preempted; preempts cyclic, periodic, battery
// - Periodic interval 10 ms to 655350 ms
// - Default periodic interval is 100 ms
// - Interrupt suspends periodic; it resumes later
// - No new periodic call before completion
// - Periodic task preempts cyclic task
// - Restart task once; absent means RUN now
// - Restart: both lamps, timers run, no irq
// - Manual restart on switch STOP to RUN
// - Power restart needs presence, RUN, battery
// - Restart tasks neither preempt nor preempted
// - Retrigger routine rearms watchdog, about 45 us
// - Battery task before cycle on battery failure
// - Call orders for switch and power cycling
// - Battery task preemptible by interrupt task
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tss_defines.vh"
`default_nettype none

module tss_scheduler #(
    parameter TICK_CYCLES   = `TSS_TICK_CYCLES,    // 10 ms tick
    parameter RETRIG_CYCLES = `TSS_RETRIG_CYCLES   // Retrigger run time
) (
    input  wire        clk_i,          // 125 MHz clock
    input  wire        rst_i,          // Sync reset, active high
    input  wire        psel_i,         // APB select
    input  wire        penable_i,      // APB enable
    input  wire        pwrite_i,       // APB direction
    input  wire [11:0] paddr_i,        // APB byte address
    input  wire [31:0] pwdata_i,       // APB write data
    output wire        pready_o,       // APB ready, always high
    output reg  [31:0] prdata_o,       // APB read data
    output wire        pslverr_o,      // APB error on unmapped
    input  wire        power_ok_i,     // Power on (async pin)
    input  wire        run_switch_i,   // Mode switch at RUN (pin)
    input  wire        battery_ok_i,   // Backup battery good (pin)
    input  wire        proc_irq_i,     // Process interrupt (pin)
    input  wire        cnt_match_i,    // Counter compare reached
    output reg  [2:0]  run_task_o,     // Task now executing
    output reg         run_mode_o,     // Controller in RUN
    output reg         led_green_o,    // Green mode lamp
    output reg         led_red_o,      // Red mode lamp
    output reg         cnt_enable_o    // Counter inputs enabled
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Two stages per pin; only stage two is read by logic
wire [4:0] pin_raw = {cnt_match_i, proc_irq_i, battery_ok_i,
                      run_switch_i, power_ok_i};
reg  [4:0] pin_s1_reg;                 // First stage
reg  [4:0] pin_s2_reg;                 // Second stage
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
        always @(posedge clk_i) begin
            if (rst_i) begin
                pin_s1_reg[gi] <= 1'b0;
                pin_s2_reg[gi] <= 1'b0;
            end else begin
                pin_s1_reg[gi] <= pin_raw[gi];
                pin_s2_reg[gi] <= pin_s1_reg[gi];
            end
        end
    end
endgenerate
wire power_ok  = pin_s2_reg[0];
wire run_sw    = pin_s2_reg[1];
wire batt_ok   = pin_s2_reg[2];
wire proc_irq  = pin_s2_reg[3];
wire cnt_match = pin_s2_reg[4];

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [2:0]  ctrl_reg;                  // Source enables, disable
reg  [15:0] period_reg;                // Interval in 10 ms ticks
reg  [6:0]  present_reg;               // Task present per code-1
reg         wdog_stop_reg;             // Watchdog forced STOP
reg  [15:0] period_cnt_reg;            // Periodic down counter
reg  [5:0]  wdog_cnt_reg;              // Watchdog tick counter
reg         wdog_armed_reg;            // Watchdog running
reg  [31:0] tick_cnt_reg;              // Tick divider
reg         tick_reg;                  // One-cycle 10 ms pulse
reg         per_pend_reg;              // Periodic call pending
reg         irq_pend_reg;              // Interrupt call pending
reg         batt_pend_reg;             // Battery task owed
reg         sw_d_reg;                  // Previous switch level
reg         pwr_d_reg;                 // Previous power level
reg         ran_before_reg;            // Was RUN at power loss
reg         rtr_busy_reg;              // Cleared at reset; never set
reg  [15:0] rtr_cnt_reg;               // Retrigger run counter
reg  [2:0]  state_reg;                 // Scheduler state
reg  [2:0]  saved_task_reg;            // Task interrupted by irq
reg  [2:0]  per_saved_reg;             // Task interrupted by per.
reg         pwr_restart_reg;           // Last restart was power
reg         irq_src_d_reg;             // Previous gated irq level

// APB decode; single-cycle slave
wire apb_wr = psel_i & penable_i & pwrite_i;
wire apb_rd = psel_i & ~penable_i & ~pwrite_i;   // Read setup phase
wire hit    = (paddr_i == `TSS_A_CTRL) | (paddr_i == `TSS_A_PERIOD) |
              (paddr_i == `TSS_A_STATUS) | (paddr_i == `TSS_A_CMD) |
              (paddr_i == `TSS_A_PRESENT);
assign pready_o  = 1'b1;
assign pslverr_o = psel_i & penable_i & ~hit;

// Command pulses from the control program
wire cmd_wr   = apb_wr & (paddr_i == `TSS_A_CMD);
wire done_p   = cmd_wr & pwdata_i[`TSS_CMD_DONE];
wire retrig_p = cmd_wr & pwdata_i[`TSS_CMD_RETRIG];
wire clrstp_p = cmd_wr & pwdata_i[`TSS_CMD_CLR_STOP];

// ----------------------------------------------------------------
// Scheduler states
// ----------------------------------------------------------------
localparam S_STOP    = 3'h0;  // Not running
localparam S_RESTART = 3'h1;  // Restart task running
localparam S_CYCLIC  = 3'h2;  // Cyclic pass
localparam S_INTR    = 3'h3;  // Interrupt task
localparam S_PERIOD  = 3'h4;  // Periodic task
localparam S_BATT    = 3'h5;  // Battery task
localparam S_RETRIG  = 3'h6;  // Retrigger routine

function present;
    input [2:0] code;
    present = present_reg[code - 3'h1];
endfunction

wire can_run  = power_ok & run_sw & ~wdog_stop_reg;
wire int_ok   = can_run & ~ctrl_reg[`TSS_CTRL_INT_DIS];
// Interrupt sources gated by their enables
wire irq_src  = (proc_irq & ctrl_reg[`TSS_CTRL_PINT_EN]) |
                (cnt_match & ctrl_reg[`TSS_CTRL_CNT_EN]);
wire sw_rise  = run_sw & ~sw_d_reg;
wire pwr_rise = power_ok & ~pwr_d_reg;
// Edge only: a source held high must not fire the task again
wire irq_rise = irq_src & ~irq_src_d_reg;

// ----------------------------------------------------------------
// Tick divider
// ----------------------------------------------------------------
// Timers keep running in every state, restart included
always @(posedge clk_i) begin
    if (rst_i) begin
        tick_cnt_reg <= 32'h0000_0000;
        tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0000_0000;
        tick_reg     <= 1'b1;
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        tick_reg     <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        ctrl_reg    <= 3'h0;
        period_reg  <= `TSS_PERIOD_DEF;
        present_reg <= `TSS_PRESENT_RST;
    end else if (apb_wr) begin
        if (paddr_i == `TSS_A_CTRL)
            ctrl_reg <= pwdata_i[2:0];
        if (paddr_i == `TSS_A_PERIOD)
            period_reg <= pwdata_i[15:0];
        if (paddr_i == `TSS_A_PRESENT)
            present_reg <= pwdata_i[6:0];
    end
end

// Read mux
always @(posedge clk_i) begin
    if (rst_i) begin
        prdata_o <= 32'h0000_0000;
    end else if (apb_rd) begin
        // Loaded in setup so the word stands at the access edge
        case (paddr_i)
            `TSS_A_CTRL:    prdata_o <= {29'h0, ctrl_reg};
            `TSS_A_PERIOD:  prdata_o <= {16'h0, period_reg};
            `TSS_A_PRESENT: prdata_o <= {25'h0, present_reg};
            `TSS_A_STATUS:  prdata_o <= {21'h00_0000, wdog_stop_reg,
                                         ~batt_ok, run_mode_o,
                                         state_reg, run_task_o,
                                         irq_pend_reg, per_pend_reg};
            default:        prdata_o <= 32'h0000_0000;
        endcase
    end
end

// ----------------------------------------------------------------
// Periodic timer
// ----------------------------------------------------------------
// Reloads on expiry; zero interval keeps the task idle
always @(posedge clk_i) begin
    if (rst_i) begin
        period_cnt_reg <= `TSS_PERIOD_DEF;
        per_pend_reg   <= 1'b0;
    end else begin
        if (period_reg == 16'h0000) begin
            period_cnt_reg <= 16'h0000;
            per_pend_reg   <= 1'b0;
        end else if (tick_reg) begin
            if (period_cnt_reg <= 16'h0001) begin
                period_cnt_reg <= period_reg;
                // Raise only when the task is not running, so a
                // call never overlaps its own predecessor
                if (int_ok & present(`TSS_T_PERIODIC) &
                    state_reg != S_PERIOD & per_saved_reg == 3'h0)
                    per_pend_reg <= 1'b1;
            end else begin
                period_cnt_reg <= period_cnt_reg - 16'h0001;
            end
        end
        if (state_reg == S_PERIOD & run_task_o == `TSS_T_PERIODIC)
            per_pend_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Scan watchdog
// ----------------------------------------------------------------
wire pass_start = state_reg == S_CYCLIC & run_task_o != `TSS_T_CYCLIC;
always @(posedge clk_i) begin
    if (rst_i) begin
        wdog_cnt_reg   <= 6'h00;
        wdog_armed_reg <= 1'b0;
        wdog_stop_reg  <= 1'b0;
    end else begin
        // Clear first so an expiry in the same cycle still wins
        if (clrstp_p & ~run_sw)
            wdog_stop_reg <= 1'b0;
        if (state_reg == S_RESTART | state_reg == S_STOP) begin
            wdog_armed_reg <= 1'b0;
        end else if (pass_start |
                     (state_reg == S_RETRIG &
                      rtr_cnt_reg == RETRIG_CYCLES - 1)) begin
            wdog_cnt_reg   <= 6'h00;
            wdog_armed_reg <= 1'b1;
        end else if (wdog_armed_reg & tick_reg) begin
            if (wdog_cnt_reg == `TSS_WDOG_TICKS - 1)
                wdog_stop_reg <= 1'b1;
            else
                wdog_cnt_reg <= wdog_cnt_reg + 6'h01;
        end
    end
end

// ----------------------------------------------------------------
// Event capture
// ----------------------------------------------------------------
// Interrupt requests are dropped outside RUN and during restart
always @(posedge clk_i) begin
    if (rst_i) begin
        irq_pend_reg   <= 1'b0;
        irq_src_d_reg  <= 1'b0;
        sw_d_reg       <= 1'b0;
        pwr_d_reg      <= 1'b0;
        ran_before_reg <= 1'b0;
    end else begin
        sw_d_reg      <= run_sw;
        pwr_d_reg     <= power_ok;
        irq_src_d_reg <= irq_src;
        if (power_ok)
            ran_before_reg <= run_mode_o;
        if (state_reg == S_INTR)
            irq_pend_reg <= 1'b0;
        if (irq_rise & int_ok & present(`TSS_T_INTR) &
            state_reg != S_RESTART & state_reg != S_STOP)
            irq_pend_reg <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Scheduler
// ----------------------------------------------------------------
// The program reports each task end with CMD.DONE; nesting depth
// inside a task is the program's own business.
always @(posedge clk_i) begin
    if (rst_i) begin
        state_reg       <= S_STOP;
        run_task_o      <= `TSS_T_NONE;
        saved_task_reg  <= 3'h0;
        per_saved_reg   <= 3'h0;
        batt_pend_reg   <= 1'b0;
        rtr_busy_reg    <= 1'b0;
        rtr_cnt_reg     <= 16'h0000;
        run_mode_o      <= 1'b0;
        pwr_restart_reg <= 1'b0;
    end else if (~can_run) begin
        state_reg      <= S_STOP;
        run_task_o     <= `TSS_T_NONE;
        saved_task_reg <= 3'h0;
        per_saved_reg  <= 3'h0;
        run_mode_o     <= 1'b0;
    end else begin
        case (state_reg)
            S_STOP: begin
                // Power return or switch edge chooses restart task
                pwr_restart_reg <= pwr_rise;
                if (pwr_rise & ran_before_reg & batt_ok &
                    present(`TSS_T_POWER)) begin
                    state_reg  <= S_RESTART;
                    run_task_o <= `TSS_T_POWER;
                end else if (sw_rise & ~pwr_rise &
                             present(`TSS_T_MANUAL)) begin
                    state_reg  <= S_RESTART;
                    run_task_o <= `TSS_T_MANUAL;
                end else begin
                    state_reg     <= S_CYCLIC;
                    run_task_o    <= `TSS_T_NONE;
                    batt_pend_reg <= ~pwr_rise;
                end
            end
            S_RESTART: begin
                // Nothing preempts a restart task
                if (done_p) begin
                    state_reg     <= S_CYCLIC;
                    run_task_o    <= `TSS_T_NONE;
                    run_mode_o    <= 1'b1;
                    batt_pend_reg <= ~pwr_restart_reg;
                end
            end
            S_CYCLIC: begin
                run_mode_o <= 1'b1;
                if (irq_pend_reg) begin
                    saved_task_reg <= run_task_o;
                    state_reg      <= S_INTR;
                    run_task_o     <= `TSS_T_INTR;
                end else if (per_pend_reg) begin
                    per_saved_reg <= run_task_o;
                    state_reg     <= S_PERIOD;
                    run_task_o    <= `TSS_T_PERIODIC;
                end else if (retrig_p) begin
                    saved_task_reg <= run_task_o;
                    state_reg      <= S_RETRIG;
                    run_task_o     <= `TSS_T_RETRIG;
                    rtr_cnt_reg    <= 16'h0000;
                end else if (run_task_o == `TSS_T_NONE) begin
                    // Cycle checkpoint
                    if (batt_pend_reg & ~batt_ok &
                        present(`TSS_T_BATT)) begin
                        state_reg  <= S_BATT;
                        run_task_o <= `TSS_T_BATT;
                    end else if (present(`TSS_T_CYCLIC)) begin
                        run_task_o <= `TSS_T_CYCLIC;
                    end
                    batt_pend_reg <= 1'b1;
                end else if (done_p) begin
                    run_task_o <= `TSS_T_NONE;
                end
            end
            S_BATT: begin
                if (irq_pend_reg) begin
                    saved_task_reg <= `TSS_T_BATT;
                    state_reg      <= S_INTR;
                    run_task_o     <= `TSS_T_INTR;
                end else if (done_p) begin
                    state_reg  <= S_CYCLIC;
                    run_task_o <= present(`TSS_T_CYCLIC) ?
                                  `TSS_T_CYCLIC : `TSS_T_NONE;
                end
            end
            S_PERIOD: begin
                if (irq_pend_reg) begin
                    saved_task_reg <= `TSS_T_PERIODIC;
                    state_reg      <= S_INTR;
                    run_task_o     <= `TSS_T_INTR;
                end else if (done_p) begin
                    state_reg     <= S_CYCLIC;
                    run_task_o    <= per_saved_reg;
                    per_saved_reg <= 3'h0;
                end
            end
            S_INTR: begin
                // Runs to its end; no preemption path here
                if (done_p) begin
                    run_task_o     <= saved_task_reg;
                    saved_task_reg <= 3'h0;
                    if (saved_task_reg == `TSS_T_PERIODIC)
                        state_reg <= S_PERIOD;
                    else if (saved_task_reg == `TSS_T_BATT)
                        state_reg <= S_BATT;
                    else
                        state_reg <= S_CYCLIC;
                end
            end
            S_RETRIG: begin
                // Fixed run time, not interruptible
                if (rtr_cnt_reg == RETRIG_CYCLES - 1) begin
                    state_reg      <= S_CYCLIC;
                    run_task_o     <= saved_task_reg;
                    saved_task_reg <= 3'h0;
                end else begin
                    rtr_cnt_reg <= rtr_cnt_reg + 16'h0001;
                end
            end
            default: begin
                state_reg  <= S_STOP;
                run_task_o <= `TSS_T_NONE;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Lamps and counter enable
// ----------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        led_green_o  <= 1'b0;
        led_red_o    <= 1'b1;
        cnt_enable_o <= 1'b0;
    end else begin
        led_green_o  <= state_reg != S_STOP;
        led_red_o    <= state_reg == S_STOP | state_reg == S_RESTART;
        cnt_enable_o <= state_reg != S_STOP & state_reg != S_RESTART;
    end
end

endmodule // tss_scheduler

`default_nettype wire

// file: verif/tss_sched_sva.sv
// Checker for the task scheduler: watches task code, mode and lamps.
// Assumes it is bound to tss_scheduler and sees its ports only.
`timescale 1ns/1ps
`include "tss_defines.vh"
`default_nettype none
module tss_sched_sva #(
    parameter RETRIG_CYCLES = 5625        // Retrigger run time
) (
    input wire logic       clk_i,         // System clock
    input wire logic       rst_i,         // Sync reset
    input wire logic [2:0] run_task_o,    // Task now executing
    input wire logic       run_mode_o,    // Controller in RUN
    input wire logic       led_green_o,   // Green lamp
    input wire logic       led_red_o,     // Red lamp
    input wire logic       cnt_enable_o   // Counter inputs on
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] ret_cnt;                 // Cycles spent retriggering
    // Counts the retrigger run so its length can be bounded
    always @(posedge clk_i) begin
        if (rst_i || run_task_o != 3'h7) ret_cnt <= 16'h0;
        else ret_cnt <= ret_cnt + 16'h1;
    end
    cyc_run_a: assert property (run_task_o == 3'h1 |-> run_mode_o)
        else $error("cyclic task outside RUN");
    intr_run_a: assert property (run_task_o == 3'h2 |-> run_mode_o)
        else $error("interrupt task outside RUN");
    batt_run_a: assert property (run_task_o == 3'h6 |-> run_mode_o)
        else $error("battery task outside RUN");
    rst_lamp_a: assert property (run_task_o inside {3'h4, 3'h5} |=>
        led_green_o && led_red_o && !cnt_enable_o)
        else $error("restart lamps or counter wrong");
    rst_hold_a: assert property (run_task_o inside {3'h4, 3'h5} |=>
        !(run_task_o inside {3'h2, 3'h3, 3'h7}))
        else $error("restart task preempted");
    intr_hold_a: assert property (run_task_o == 3'h2 |=>
        !(run_task_o inside {3'h4, 3'h5}))
        else $error("interrupt task left for restart");
    retrig_min_a: assert property ($rose(run_task_o == 3'h7) |->
        (run_task_o == 3'h7) [*2])
        else $error("retrigger cut short");
    retrig_len_a: assert property (run_task_o == 3'h7 |->
        ret_cnt <= RETRIG_CYCLES + 1)
        else $error("retrigger runs too long");
    stop_lamp_a: assert property ($fell(run_mode_o) |=>
        led_red_o && !led_green_o)
        else $error("STOP without red lamp");
    rst_c: cover property (run_task_o == 3'h4);
    intr_c: cover property (run_task_o == 3'h2);
    per_c: cover property (run_task_o == 3'h3);
endmodule // tss_sched_sva
bind tss_scheduler tss_sched_sva #(.RETRIG_CYCLES(RETRIG_CYCLES))
    i_tss_sched_sva (.clk_i(clk_i), .rst_i(rst_i), .run_task_o(run_task_o),
    .run_mode_o(run_mode_o), .led_green_o(led_green_o),
    .led_red_o(led_red_o), .cnt_enable_o(cnt_enable_o));
`default_nettype wire

// file: verif/tss_prog_model.sv
// Model of the far side: supply, mode switch, battery and event pins.
// Assumes set_pins is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tss_prog_model (
    output var logic power_ok_o,   // Supply good
    output var logic run_sw_o,     // Switch at RUN
    output var logic batt_ok_o,    // Backup battery good
    output var logic irq_o,        // Process interrupt level
    output var logic match_o       // Counter compare reached
);
    initial {power_ok_o, run_sw_o, batt_ok_o, irq_o, match_o} = 5'h0;
    // Levels move by NBA; program issues no nested calls at all
    task automatic set_pins(input logic p, s, b, i, m);
        {power_ok_o, run_sw_o, batt_ok_o, irq_o, match_o} <= {p, s, b, i, m};
    endtask
endmodule // tss_prog_model
`default_nettype wire

// file: verif/tb_task_scheduler_scan_watchdog.sv
// Testbench: APB master plus pin model around the task scheduler.
// Assumes a shortened tick of 10 cycles and retrigger of 4 cycles.
`timescale 1ns/1ps
`include "tss_defines.vh"
`default_nettype none
module tb_task_scheduler_scan_watchdog;
    logic        clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire  [2:0]  tsk;
    wire         pready, pslverr, mode, grn, red, cen, pw, sw, bt, irq, cm;
    int          err_count = 0, tests_run = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    tss_prog_model i_tss_prog_model (.power_ok_o(pw), .run_sw_o(sw),
        .batt_ok_o(bt), .irq_o(irq), .match_o(cm));
    tss_scheduler #(.TICK_CYCLES(10), .RETRIG_CYCLES(4)) i_tss_scheduler (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .power_ok_i(pw), .run_switch_i(sw), .battery_ok_i(bt),
        .proc_irq_i(irq), .cnt_match_i(cm), .run_task_o(tsk),
        .run_mode_o(mode), .led_green_o(grn), .led_red_o(red),
        .cnt_enable_o(cen));
    task automatic chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Setup then access; result taken at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i) pen <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_task(input logic [2:0] c);
        int n = 0;
        while (tsk !== c && n < 600) begin @(posedge clk_i); n++; end
        chk(tsk, c);
    endtask
    task automatic done(); apb(1, `TSS_A_CMD, 1); endtask
    task automatic t_reset();
        apb(0, `TSS_A_PERIOD, 0); chk(rd, 32'hA);
        apb(0, `TSS_A_PRESENT, 0); chk(rd[6:0], 7'h7F);
        apb(0, 12'h020, 0); chk(err, 1'b1);
        chk({tsk, mode, red}, 5'h1);
        $display("reset test over");
    endtask
    task automatic t_restart();
        i_tss_prog_model.set_pins(1, 0, 1, 0, 0);
        repeat (4) @(posedge clk_i);
        i_tss_prog_model.set_pins(1, 1, 1, 0, 0);
        wait_task(3'h4);
        @(posedge clk_i);
        chk({grn, red, cen}, 3'h6);
        done(); wait_task(3'h1);
        chk(mode, 1'b1);
        $display("restart test over");
    endtask
    task automatic t_periodic();
        done(); apb(1, `TSS_A_PERIOD, 2);
        wait_task(3'h3);
        apb(1, `TSS_A_CTRL, 1);
        i_tss_prog_model.set_pins(1, 1, 1, 1, 0);
        wait_task(3'h2);
        i_tss_prog_model.set_pins(1, 1, 1, 0, 0);
        done(); wait_task(3'h3);
        apb(1, `TSS_A_PERIOD, 0);
        done(); wait_task(3'h1);
        $display("periodic test over");
    endtask
    task automatic t_irq();
        done(); apb(1, `TSS_A_CTRL, 2);
        i_tss_prog_model.set_pins(1, 1, 1, 0, 1);
        wait_task(3'h2);
        i_tss_prog_model.set_pins(1, 1, 1, 0, 0);
        done(); wait_task(3'h1);
        apb(1, `TSS_A_CTRL, 5);
        i_tss_prog_model.set_pins(1, 1, 1, 1, 0);
        repeat (20) @(posedge clk_i);
        chk(tsk, 3'h1);
        i_tss_prog_model.set_pins(1, 1, 1, 0, 0);
        $display("interrupt test over");
    endtask
    task automatic t_wdog();
        int n = 0;
        i_tss_prog_model.set_pins(1, 1, 0, 0, 0);
        done(); wait_task(3'h6);
        done(); wait_task(3'h1);
        apb(1, `TSS_A_CMD, 2); wait_task(3'h7);
        wait_task(3'h1);
        while (mode !== 1'b0 && n < 400) begin @(posedge clk_i); n++; end
        @(posedge clk_i);
        chk({mode, red, n > 250}, 3'h3);
        $display("watchdog test over");
    endtask
    task automatic test_done();
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin err_count++; test_done(); end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset(); t_restart(); t_periodic(); t_irq(); t_wdog();
        test_done();
    end
endmodule // tb_task_scheduler_scan_watchdog
`default_nettype wire
